// [logic/csb_compare.v]
`timescale 1ns/1ns
`default_nettype none
`include "csb_defs.vh"

// ---------------------------------------------------------------
// Subtract without store, flag generation
// ---------------------------------------------------------------
module csb_compare (
  // Operands
  input wire [7:0] minuend,
  input wire [7:0] subtrahend,
  input wire carry_in,
  input wire zero_in,
  input wire chain_zero,
  // Result and flags
  output wire [7:0] result,
  output wire flag_z,
  output wire flag_n,
  output wire flag_v,
  output wire flag_c,
  output wire flag_h
);
  wire [7:0] d;
  wire [7:0] r;
  assign d = minuend;
  assign r = subtrahend;
  assign result = d - r - {7'h00, carry_in};
  // Chained compare keeps zero only while every byte matched
  assign flag_z = (result == 8'h00) & (~chain_zero | zero_in);
  assign flag_n = result[7];
  assign flag_v = (d[7] & ~r[7] & ~result[7]) | (~d[7] & r[7] & result[7]);
  assign flag_c = (~d[7] & r[7]) | (r[7] & result[7]) | (result[7] & ~d[7]);
  assign flag_h = (~d[3] & r[3]) | (r[3] & result[3]) | (result[3] & ~d[3]);
endmodule // csb_compare
`default_nettype wire

// [logic/csb_condition.v]
`timescale 1ns/1ns
`default_nettype none
`include "csb_defs.vh"

// ---------------------------------------------------------------
// Skip and branch condition selection
// ---------------------------------------------------------------
module csb_condition (
  // Instruction
  input wire [`CSB_OP_WIDTH-1:0] op,
  input wire [2:0] bit_sel,
  // Operands
  input wire [7:0] operand_d,
  input wire [7:0] operand_r,
  input wire [7:0] io_data,
  input wire [7:0] status,
  // Decode
  output reg is_skip,
  output reg is_branch,
  output reg is_compare,
  output reg is_known,
  output reg cond_true
);
  reg [2:0] flag_idx;
  reg polarity;

  always @* begin
    is_skip = 1'b0;
    is_branch = 1'b0;
    is_compare = 1'b0;
    is_known = 1'b1;
    cond_true = 1'b0;
    flag_idx = bit_sel;
    polarity = 1'b1;
    case (op)
      `CSB_OP_COMPARE_AND_SKIP_IF_EQUAL: begin
        is_skip = 1'b1;
        cond_true = (operand_d == operand_r);
      end
      `CSB_OP_COMPARE_REGISTERS,
      `CSB_OP_COMPARE_WITH_CARRY,
      `CSB_OP_COMPARE_IMMEDIATE: begin
        is_compare = 1'b1;
      end
      `CSB_OP_SKIP_IF_REG_BIT_CLEAR: begin
        is_skip = 1'b1;
        cond_true = ~operand_r[bit_sel];
      end
      `CSB_OP_SKIP_IF_REG_BIT_SET: begin
        is_skip = 1'b1;
        cond_true = operand_r[bit_sel];
      end
      `CSB_OP_SKIP_IF_IO_BIT_CLEAR: begin
        is_skip = 1'b1;
        cond_true = ~io_data[bit_sel];
      end
      `CSB_OP_SKIP_IF_IO_BIT_SET: begin
        is_skip = 1'b1;
        cond_true = io_data[bit_sel];
      end
      `CSB_OP_BRANCH_ON_FLAG_SET: begin
        is_branch = 1'b1;
      end
      `CSB_OP_BRANCH_ON_FLAG_CLEAR: begin
        is_branch = 1'b1;
        polarity = 1'b0;
      end
      `CSB_OP_BRANCH_ON_EQUAL: begin
        is_branch = 1'b1;
        flag_idx = `CSB_FLAG_IDX_Z;
      end
      `CSB_OP_BRANCH_ON_NOT_EQUAL: begin
        is_branch = 1'b1;
        flag_idx = `CSB_FLAG_IDX_Z;
        polarity = 1'b0;
      end
      `CSB_OP_BRANCH_ON_CARRY_SET,
      `CSB_OP_BRANCH_UNSIGNED_LOWER: begin
        is_branch = 1'b1;
        flag_idx = `CSB_FLAG_IDX_C;
      end
      `CSB_OP_BRANCH_ON_CARRY_CLEAR,
      `CSB_OP_BRANCH_UNSIGNED_HIGHER_OR_SAME: begin
        is_branch = 1'b1;
        flag_idx = `CSB_FLAG_IDX_C;
        polarity = 1'b0;
      end
      `CSB_OP_BRANCH_ON_MINUS: begin
        is_branch = 1'b1;
        flag_idx = `CSB_FLAG_IDX_N;
      end
      default: begin
        is_known = 1'b0;
      end
    endcase
    if (is_branch) begin
      cond_true = (status[flag_idx] == polarity);
    end
  end
endmodule // csb_condition
`default_nettype wire

// [logic/csb_defs.vh]
`ifndef CSB_DEFS_VH
`define CSB_DEFS_VH

// ---------------------------------------------------------------
// Operation codes
// ---------------------------------------------------------------
`define CSB_OP_WIDTH 5
`define CSB_OP_COMPARE_AND_SKIP_IF_EQUAL 5'h00
`define CSB_OP_COMPARE_REGISTERS 5'h01
`define CSB_OP_COMPARE_WITH_CARRY 5'h02
`define CSB_OP_COMPARE_IMMEDIATE 5'h03
`define CSB_OP_SKIP_IF_REG_BIT_CLEAR 5'h04
`define CSB_OP_SKIP_IF_REG_BIT_SET 5'h05
`define CSB_OP_SKIP_IF_IO_BIT_CLEAR 5'h06
`define CSB_OP_SKIP_IF_IO_BIT_SET 5'h07
`define CSB_OP_BRANCH_ON_FLAG_SET 5'h08
`define CSB_OP_BRANCH_ON_FLAG_CLEAR 5'h09
`define CSB_OP_BRANCH_ON_EQUAL 5'h0a
`define CSB_OP_BRANCH_ON_NOT_EQUAL 5'h0b
`define CSB_OP_BRANCH_ON_CARRY_SET 5'h0c
`define CSB_OP_BRANCH_ON_CARRY_CLEAR 5'h0d
`define CSB_OP_BRANCH_UNSIGNED_HIGHER_OR_SAME 5'h0e
`define CSB_OP_BRANCH_UNSIGNED_LOWER 5'h0f
`define CSB_OP_BRANCH_ON_MINUS 5'h10

// ---------------------------------------------------------------
// Status register field positions
// ---------------------------------------------------------------
`define CSB_FLAG_C 0
`define CSB_FLAG_Z 1
`define CSB_FLAG_N 2
`define CSB_FLAG_V 3
`define CSB_FLAG_S 4
`define CSB_FLAG_H 5
`define CSB_FLAG_T 6
`define CSB_FLAG_I 7
`define CSB_FLAG_IDX_C 3'h0
`define CSB_FLAG_IDX_Z 3'h1
`define CSB_FLAG_IDX_N 3'h2

// ---------------------------------------------------------------
// Register offsets and reset values
// ---------------------------------------------------------------
`define CSB_ADDR_WIDTH 4
`define CSB_REG_STATUS 4'h0
`define CSB_REG_PC_LOW 4'h1
`define CSB_REG_PC_HIGH 4'h2
`define CSB_REG_UNIT 4'h3
`define CSB_STATUS_RESET 8'h00
`define CSB_UNIT_BUSY 0
`define CSB_UNIT_SKIPPED 1
`define CSB_UNIT_BRANCHED 2
`define CSB_UNIT_UNKNOWN_OP 3

// ---------------------------------------------------------------
// Cycle counts
// ---------------------------------------------------------------
`define CSB_CYC_PLAIN 2'h1
`define CSB_CYC_SKIP_ONE 2'h2
`define CSB_CYC_SKIP_TWO 2'h3
`define CSB_CYC_BRANCH_TAKEN 2'h2

`endif

// [logic/csb_unit.v]
`timescale 1ns/1ns
`default_nettype none
`include "csb_defs.vh"

module csb_unit #(
  parameter PC_WIDTH = 16,
  parameter K_WIDTH = 7
) (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // Instruction issue
  input wire issue_valid,
  input wire [`CSB_OP_WIDTH-1:0] issue_op,
  input wire [PC_WIDTH-1:0] issue_pc,
  input wire [7:0] operand_d,
  input wire [7:0] operand_r,
  input wire [7:0] immediate,
  input wire [2:0] bit_sel,
  input wire [7:0] io_data,
  input wire [K_WIDTH-1:0] offset_k,
  input wire next_two_word,
  // Register port
  input wire [`CSB_ADDR_WIDTH-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  // Completion
  output reg busy,
  output reg done,
  output reg [PC_WIDTH-1:0] pc_out,
  output reg skip_taken,
  output reg branch_taken,
  output reg [7:0] status_out
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  reg rst_meta_reg;
  reg rst_sync_reg;
  wire rst_n;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // ---------------------------------------------------------------
  // Program counter helpers
  // ---------------------------------------------------------------
  // Word step added to an instruction address, wraps at the top
  function [PC_WIDTH-1:0] pc_step;
    input [PC_WIDTH-1:0] base;
    input [1:0] words;
    begin
      pc_step = base + {{(PC_WIDTH-2){1'b0}}, words};
    end
  endfunction

  // Upper byte of the counter, zero padded for short counters
  function [7:0] pc_high_byte;
    input [PC_WIDTH-1:0] pc;
    reg [PC_WIDTH+7:0] padded;
    begin
      padded = {8'h00, pc};
      pc_high_byte = padded[15:8];
    end
  endfunction

  // ---------------------------------------------------------------
  // Decode and compare
  // ---------------------------------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [1:0] count_reg;
  reg [1:0] count_next;
  reg [7:0] status_reg;
  reg [7:0] status_next;
  reg [PC_WIDTH-1:0] pc_reg;
  reg [PC_WIDTH-1:0] pc_next;
  reg skip_reg;
  reg skip_next;
  reg branch_reg;
  reg branch_next;
  reg unknown_reg;
  reg unknown_next;
  reg done_next;

  wire is_skip;
  wire is_branch;
  wire is_compare;
  wire is_known;
  wire cond_true;
  wire [7:0] cmp_sub;
  wire cmp_with_carry;
  wire cmp_z;
  wire cmp_n;
  wire cmp_v;
  wire cmp_c;
  wire cmp_h;
  wire accept;
  wire [PC_WIDTH-1:0] pc_inc;
  wire [PC_WIDTH-1:0] k_ext;

  // New work only while idle; requests during wait cycles are dropped
  assign accept = issue_valid & state_reg[0];
  assign cmp_with_carry = (issue_op == `CSB_OP_COMPARE_WITH_CARRY);
  // Immediate form swaps the constant in as subtrahend
  assign cmp_sub = (issue_op == `CSB_OP_COMPARE_IMMEDIATE) ? immediate : operand_r;
  assign pc_inc = pc_step(issue_pc, 2'h1);
  // Signed word offset widened to the counter
  assign k_ext = {{(PC_WIDTH-K_WIDTH){offset_k[K_WIDTH-1]}}, offset_k};

  // ---------------------------------------------------------------
  // Condition and compare datapath
  // ---------------------------------------------------------------
  csb_condition u_condition (
    .op(issue_op),
    .bit_sel(bit_sel),
    .operand_d(operand_d),
    .operand_r(operand_r),
    .io_data(io_data),
    .status(status_reg),
    .is_skip(is_skip),
    .is_branch(is_branch),
    .is_compare(is_compare),
    .is_known(is_known),
    .cond_true(cond_true)
  );

  csb_compare u_compare (
    .minuend(operand_d),
    .subtrahend(cmp_sub),
    .carry_in(cmp_with_carry & status_reg[`CSB_FLAG_C]),
    .zero_in(status_reg[`CSB_FLAG_Z]),
    .chain_zero(cmp_with_carry),
    .result(),
    .flag_z(cmp_z),
    .flag_n(cmp_n),
    .flag_v(cmp_v),
    .flag_c(cmp_c),
    .flag_h(cmp_h)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    status_next = status_reg;
    pc_next = pc_reg;
    skip_next = skip_reg;
    branch_next = branch_reg;
    unknown_next = unknown_reg;
    done_next = 1'b0;
    // Software write loses to a compare in the same cycle on the C, Z, N, V and H bits
    if (reg_write && reg_addr == `CSB_REG_STATUS) begin
      status_next = reg_wdata;
    end
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          skip_next = 1'b0;
          branch_next = 1'b0;
          unknown_next = ~is_known;
          pc_next = pc_inc;
          count_next = `CSB_CYC_PLAIN;
          if (is_compare) begin
            status_next[`CSB_FLAG_Z] = cmp_z;
            status_next[`CSB_FLAG_N] = cmp_n;
            status_next[`CSB_FLAG_V] = cmp_v;
            status_next[`CSB_FLAG_C] = cmp_c;
            status_next[`CSB_FLAG_H] = cmp_h;
          end
          if (is_skip && cond_true) begin
            skip_next = 1'b1;
            if (next_two_word) begin
              pc_next = pc_step(issue_pc, 2'h3);
              count_next = `CSB_CYC_SKIP_TWO;
            end else begin
              pc_next = pc_step(issue_pc, 2'h2);
              count_next = `CSB_CYC_SKIP_ONE;
            end
          end
          if (is_branch && cond_true) begin
            branch_next = 1'b1;
            pc_next = pc_inc + k_ext;
            count_next = `CSB_CYC_BRANCH_TAKEN;
          end
          if (count_next == `CSB_CYC_PLAIN) begin
            done_next = 1'b1;
          end else begin
            state_next = ST_WAIT;
            count_next = count_next - 2'h1;
          end
        end
      end
      ST_WAIT: begin
        count_next = count_reg - 2'h1;
        if (count_reg == 2'h1) begin
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      count_reg <= 2'h0;
      status_reg <= `CSB_STATUS_RESET;
      pc_reg <= {PC_WIDTH{1'b0}};
      skip_reg <= 1'b0;
      branch_reg <= 1'b0;
      unknown_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      status_reg <= status_next;
      pc_reg <= pc_next;
      skip_reg <= skip_next;
      branch_reg <= branch_next;
      unknown_reg <= unknown_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      pc_out <= {PC_WIDTH{1'b0}};
      skip_taken <= 1'b0;
      branch_taken <= 1'b0;
      status_out <= `CSB_STATUS_RESET;
    end else begin
      // Busy follows the next state so it lines up with pc_out
      busy <= state_next[1];
      done <= done_next;
      pc_out <= pc_next;
      skip_taken <= skip_next;
      branch_taken <= branch_next;
      status_out <= status_next;
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `CSB_REG_STATUS: reg_rdata <= status_reg;
        `CSB_REG_PC_LOW: reg_rdata <= pc_reg[7:0];
        `CSB_REG_PC_HIGH: reg_rdata <= pc_high_byte(pc_reg);
        `CSB_REG_UNIT: reg_rdata <= {4'h0, unknown_reg, branch_reg, skip_reg, state_reg[1]};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // csb_unit
`default_nettype wire

// [testbench/csb_unit_checker.sv]
`timescale 1ns/1ns
`default_nettype none
`include "csb_defs.vh"

// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module csb_unit_checker #(
  parameter PC_WIDTH = 16,
  parameter K_WIDTH = 7
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Issue
  input wire logic issue_valid,
  input wire logic [`CSB_OP_WIDTH-1:0] issue_op,
  input wire logic [PC_WIDTH-1:0] issue_pc,
  input wire logic [7:0] operand_d,
  input wire logic [7:0] operand_r,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] io_data,
  input wire logic [K_WIDTH-1:0] offset_k,
  input wire logic next_two_word,
  // Register port
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Completion
  input wire logic busy,
  input wire logic done,
  input wire logic [PC_WIDTH-1:0] pc_out,
  input wire logic skip_taken,
  input wire logic branch_taken,
  input wire logic [7:0] status_out
);
  wire logic acc = issue_valid && !busy;
  wire logic is_skip = issue_op == `CSB_OP_COMPARE_AND_SKIP_IF_EQUAL || issue_op[4:2] == 3'b001;
  wire logic [PC_WIDTH-1:0] tgt = issue_pc + 1'b1 +
    {{(PC_WIDTH-K_WIDTH){offset_k[K_WIDTH-1]}}, offset_k};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_wait1;
    busy && !done ##1 done && !busy;
  endsequence

  a_cmp_flags:
  assert property (acc && issue_op == `CSB_OP_COMPARE_REGISTERS && !reg_write |=> done && !busy
    && status_out[1] == ($past(operand_d) == $past(operand_r))
    && status_out[0] == ($past(operand_d) < $past(operand_r)))
    else $error("compare flags or timing wrong");
  a_br_taken:
  assert property (acc && issue_op == `CSB_OP_BRANCH_ON_EQUAL && status_out[1]
    |=> (branch_taken && pc_out == $past(tgt)) ##0 s_wait1)
    else $error("taken branch target or timing wrong");
  a_br_not_taken:
  assert property (acc && issue_op == `CSB_OP_BRANCH_ON_NOT_EQUAL && status_out[1]
    |=> done && !busy && !branch_taken && pc_out == $past(issue_pc) + 1'b1)
    else $error("untaken branch wrong");
  a_skip_flags:
  assert property (acc && is_skip && !reg_write |=> status_out == $past(status_out))
    else $error("skip changed flags");
  a_skip_two:
  assert property (acc && issue_op == `CSB_OP_SKIP_IF_REG_BIT_SET && operand_r[bit_sel]
    && next_two_word |=> (skip_taken && pc_out == $past(issue_pc) + 2'd3)
    ##0 busy && !done ##1 s_wait1)
    else $error("two word skip wrong");
  a_io_skip_one:
  assert property (acc && issue_op == `CSB_OP_SKIP_IF_IO_BIT_CLEAR && !io_data[bit_sel]
    && !next_two_word |=> (skip_taken && pc_out == $past(issue_pc) + 2'd2) ##0 s_wait1)
    else $error("io skip wrong");
  a_eq_skip_miss:
  assert property (acc && issue_op == `CSB_OP_COMPARE_AND_SKIP_IF_EQUAL
    && operand_d != operand_r |=> done && !skip_taken && pc_out == $past(issue_pc) + 1'b1)
    else $error("unequal compare skipped");
  a_done_bound:
  assert property (acc |=> ##[0:2] done)
    else $error("done late");
  a_rdata_idle:
  assert property (!reg_read |=> reg_rdata == 8'h00)
    else $error("read data not idle");
endmodule // csb_unit_checker

bind csb_unit csb_unit_checker #(.PC_WIDTH(PC_WIDTH), .K_WIDTH(K_WIDTH)) csb_unit_checker_inst (
  .clock(clock), .rstn(rstn), .issue_valid(issue_valid), .issue_op(issue_op),
  .issue_pc(issue_pc), .operand_d(operand_d), .operand_r(operand_r), .bit_sel(bit_sel),
  .io_data(io_data), .offset_k(offset_k), .next_two_word(next_two_word),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .busy(busy),
  .done(done), .pc_out(pc_out), .skip_taken(skip_taken), .branch_taken(branch_taken),
  .status_out(status_out)
);

`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "csb_defs.vh"

module testbench;
  logic clock, rstn, issue_valid, next_two_word, reg_write, reg_read;
  logic busy, done, skip_taken, branch_taken;
  logic [4:0] issue_op;
  logic [15:0] issue_pc, pc_out, ncyc;
  logic [7:0] operand_d, operand_r, immediate, io_data, reg_wdata, reg_rdata, status_out;
  logic [2:0] bit_sel;
  logic [6:0] offset_k;
  logic [3:0] reg_addr;
  int miscompares = 0;
  int samples_checked = 0;

  csb_unit csb_unit_inst (
    .clock(clock), .rstn(rstn), .issue_valid(issue_valid), .issue_op(issue_op),
    .issue_pc(issue_pc), .operand_d(operand_d), .operand_r(operand_r),
    .immediate(immediate), .bit_sel(bit_sel), .io_data(io_data), .offset_k(offset_k),
    .next_two_word(next_two_word), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .busy(busy),
    .done(done), .pc_out(pc_out), .skip_taken(skip_taken), .branch_taken(branch_taken),
    .status_out(status_out)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic exec(input logic [4:0] op, input logic [15:0] pc, input logic [7:0] d, r, io,
      input logic [2:0] b, input logic [6:0] k, input logic tw);
    @(posedge clock);
    issue_op <= op;
    issue_pc <= pc;
    operand_d <= d;
    operand_r <= r;
    immediate <= r;
    io_data <= io;
    bit_sel <= b;
    offset_k <= k;
    next_two_word <= tw;
    issue_valid <= 1'b1;
    @(posedge clock);
    issue_valid <= 1'b0;
    #1;
    ncyc = 16'h0001;
    while (done !== 1'b1 && ncyc < 16'h0005) begin
      @(posedge clock);
      #1;
      ncyc++;
    end
  endtask

  task automatic cmp(input logic [4:0] op, input logic [7:0] d, r, st);
    exec(op, 16'h0010, d, r, 8'h00, 3'h0, 7'h00, 1'b0);
    chk(ncyc, 16'h0001);
    chk(pc_out, 16'h0011);
    chk(status_out, st);
  endtask

  task automatic sk(input logic [4:0] op, input logic [7:0] d, r, io, input logic [2:0] b,
      input logic tw, t);
    exec(op, 16'h0100, d, r, io, b, 7'h00, tw);
    chk(ncyc, 16'h0001 + {14'h0000, t & tw, t & ~tw});
    chk(pc_out, 16'h0101 + {14'h0000, t & tw, t & ~tw});
    chk(skip_taken, t);
    chk(status_out, 8'h28);
  endtask

  task automatic br(input logic [7:0] st, input logic [4:0] op, input logic [2:0] b,
      input logic [6:0] k, input logic t);
    wr(`CSB_REG_STATUS, st);
    exec(op, 16'h0200, 8'h00, 8'h00, 8'h00, b, k, 1'b0);
    chk(ncyc, t ? 16'h0002 : 16'h0001);
    chk(pc_out, t ? 16'h0201 + {{9{k[6]}}, k} : 16'h0201);
    chk(branch_taken, t);
    chk(status_out, st);
  endtask

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    #40000;
    miscompares++;
    finish_test();
  end

  initial begin
    rstn = 1'b0;
    {issue_valid, next_two_word, reg_write, reg_read} = 4'h0;
    {issue_op, issue_pc, operand_d, operand_r, immediate} = 45'h0;
    {io_data, bit_sel, offset_k, reg_addr, reg_wdata} = 30'h0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    rd(`CSB_REG_STATUS, `CSB_STATUS_RESET);
    wr(`CSB_REG_STATUS, 8'ha5);
    rd(`CSB_REG_STATUS, 8'ha5);
    rd(4'hf, 8'h00);
    wr(`CSB_REG_STATUS, 8'h00);
    cmp(`CSB_OP_COMPARE_REGISTERS, 8'h05, 8'h05, 8'h02);
    cmp(`CSB_OP_COMPARE_WITH_CARRY, 8'h05, 8'h05, 8'h02);
    cmp(`CSB_OP_COMPARE_REGISTERS, 8'h03, 8'h05, 8'h25);
    cmp(`CSB_OP_COMPARE_WITH_CARRY, 8'h06, 8'h05, 8'h00);
    cmp(`CSB_OP_COMPARE_IMMEDIATE, 8'h80, 8'h01, 8'h28);
    sk(`CSB_OP_COMPARE_AND_SKIP_IF_EQUAL, 8'h5a, 8'h5a, 8'h00, 3'h0, 1'b0, 1'b1);
    sk(`CSB_OP_COMPARE_AND_SKIP_IF_EQUAL, 8'h5a, 8'h5b, 8'h00, 3'h0, 1'b1, 1'b0);
    sk(`CSB_OP_SKIP_IF_REG_BIT_CLEAR, 8'h00, 8'hfb, 8'h00, 3'h2, 1'b0, 1'b1);
    sk(`CSB_OP_SKIP_IF_REG_BIT_CLEAR, 8'h00, 8'h04, 8'h00, 3'h2, 1'b1, 1'b0);
    sk(`CSB_OP_SKIP_IF_REG_BIT_SET, 8'h00, 8'h80, 8'h00, 3'h7, 1'b1, 1'b1);
    sk(`CSB_OP_SKIP_IF_REG_BIT_SET, 8'h00, 8'h7f, 8'h00, 3'h7, 1'b0, 1'b0);
    sk(`CSB_OP_SKIP_IF_IO_BIT_CLEAR, 8'h00, 8'h00, 8'hfe, 3'h0, 1'b0, 1'b1);
    sk(`CSB_OP_SKIP_IF_IO_BIT_CLEAR, 8'h00, 8'h00, 8'h01, 3'h0, 1'b0, 1'b0);
    sk(`CSB_OP_SKIP_IF_IO_BIT_SET, 8'h00, 8'h00, 8'h10, 3'h4, 1'b1, 1'b1);
    sk(`CSB_OP_SKIP_IF_IO_BIT_SET, 8'h00, 8'h00, 8'hef, 3'h4, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      br(8'h01 << i, `CSB_OP_BRANCH_ON_FLAG_SET, i[2:0], 7'h04, 1'b1);
      br(~(8'h01 << i), `CSB_OP_BRANCH_ON_FLAG_SET, i[2:0], 7'h7c, 1'b0);
      br(~(8'h01 << i), `CSB_OP_BRANCH_ON_FLAG_CLEAR, i[2:0], 7'h7c, 1'b1);
      br(8'h01 << i, `CSB_OP_BRANCH_ON_FLAG_CLEAR, i[2:0], 7'h04, 1'b0);
    end
    br(8'h05, `CSB_OP_BRANCH_ON_CARRY_SET, 3'h0, 7'h40, 1'b1);
    br(8'h05, `CSB_OP_BRANCH_ON_CARRY_CLEAR, 3'h0, 7'h01, 1'b0);
    br(8'h02, `CSB_OP_BRANCH_ON_CARRY_CLEAR, 3'h0, 7'h05, 1'b1);
    br(8'h05, `CSB_OP_BRANCH_UNSIGNED_HIGHER_OR_SAME, 3'h0, 7'h01, 1'b0);
    br(8'h02, `CSB_OP_BRANCH_UNSIGNED_HIGHER_OR_SAME, 3'h0, 7'h05, 1'b1);
    br(8'h05, `CSB_OP_BRANCH_UNSIGNED_LOWER, 3'h0, 7'h3f, 1'b1);
    br(8'h02, `CSB_OP_BRANCH_UNSIGNED_LOWER, 3'h0, 7'h05, 1'b0);
    br(8'h05, `CSB_OP_BRANCH_ON_MINUS, 3'h0, 7'h7f, 1'b1);
    br(8'h02, `CSB_OP_BRANCH_ON_MINUS, 3'h0, 7'h05, 1'b0);
    br(8'h02, `CSB_OP_BRANCH_ON_EQUAL, 3'h0, 7'h00, 1'b1);
    br(8'h05, `CSB_OP_BRANCH_ON_EQUAL, 3'h0, 7'h03, 1'b0);
    br(8'h05, `CSB_OP_BRANCH_ON_NOT_EQUAL, 3'h0, 7'h01, 1'b1);
    br(8'h02, `CSB_OP_BRANCH_ON_NOT_EQUAL, 3'h0, 7'h01, 1'b0);
    exec(5'h1f, 16'h1234, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0);
    chk(pc_out, 16'h1235);
    rd(`CSB_REG_UNIT, 8'h08);
    rd(`CSB_REG_PC_LOW, 8'h35);
    rd(`CSB_REG_PC_HIGH, 8'h12);
    // Mid-run reset clears the outputs, then the unit takes work again
    @(posedge clock);
    rstn <= 1'b0;
    @(posedge clock);
    rstn <= 1'b1;
    #1;
    chk(pc_out, 16'h0000);
    chk(status_out, `CSB_STATUS_RESET);
    repeat (3) @(posedge clock);
    cmp(`CSB_OP_COMPARE_REGISTERS, 8'h05, 8'h06, 8'h25);
    finish_test();
  end
endmodule // testbench

`default_nettype wire
